// >>> src/osdc_defines.svh
// constants for the octal serial driver control link and its two ends
// assumes a 200 MHz system clock at both ends
`ifndef OSDC_DEFINES_SVH
`define OSDC_DEFINES_SVH
// ------------------------------------------------------------
// widths and positions
// ------------------------------------------------------------
`define OSDC_WIDTH 8
`define OSDC_MSB 7
`define OSDC_CNT_W 16
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OSDC_CLK_PERIOD_NS 5
`define OSDC_BLANK_NS 135000
`define OSDC_BLANK_CYCLES (`OSDC_BLANK_NS / `OSDC_CLK_PERIOD_NS)
`define OSDC_SETTLE_NS 260000
`define OSDC_SETTLE_CYCLES (`OSDC_SETTLE_NS / `OSDC_CLK_PERIOD_NS)
`define OSDC_HALF_NS 1000
`define OSDC_HALF_CYCLES (`OSDC_HALF_NS / `OSDC_CLK_PERIOD_NS)
// ------------------------------------------------------------
// synchronised pin vector positions and its idle value
// ------------------------------------------------------------
`define OSDC_PIN_SI 0
`define OSDC_PIN_SCLK 1
`define OSDC_PIN_CE_N 2
`define OSDC_PIN_RST_N 3
`define OSDC_PIN_IDLE 4'hC
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define OSDC_BYTE_ZERO 8'h00
`define OSDC_BYTE_OFF 8'hFF
`endif

// >>> src/osdc_device.sv
// device end: shift register, output latch, fault blanking timer
// assumes link pins are asynchronous to clk; they pass two flops first
`include "osdc_defines.svh"
`default_nettype none
module osdc_device
   import osdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   osdc_link_if.device link,
   input wire logic [`OSDC_WIDTH-1:0] out_high,
   output logic [`OSDC_WIDTH-1:0] drive_on,
   output logic blanking
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_s1_reg; // first stage, read only by second
   logic [3:0] pin_s2_reg; // {reset_n, ce_n, sclk, si}
   logic [`OSDC_WIDTH-1:0] cmp_s1_reg; // comparator first stage
   logic [`OSDC_WIDTH-1:0] cmp_s2_reg; // comparator flags
   logic sclk_d_reg; // previous synchronised clock
   logic ce_n_d_reg; // previous synchronised enable

   // two flops per pin; reset held high defaults to inactive pins
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_reg <= `OSDC_PIN_IDLE;
         pin_s2_reg <= `OSDC_PIN_IDLE;
         cmp_s1_reg <= `OSDC_BYTE_ZERO;
         cmp_s2_reg <= `OSDC_BYTE_ZERO;
         sclk_d_reg <= 1'b0;
         ce_n_d_reg <= 1'b1;
      end else if (ce) begin
         pin_s1_reg <= {link.reset_n, link.ce_n, link.sclk, link.si};
         pin_s2_reg <= pin_s1_reg;
         cmp_s1_reg <= out_high;
         cmp_s2_reg <= cmp_s1_reg;
         sclk_d_reg <= pin_s2_reg[`OSDC_PIN_SCLK];
         ce_n_d_reg <= pin_s2_reg[`OSDC_PIN_CE_N];
      end
   end

   // decoded events
   logic pin_rst; // pin reset active
   logic sel; // chip selected
   logic ce_fall; // selection starts
   logic ce_rise; // selection ends
   logic sclk_rise; // serial clock up while selected
   logic sclk_fall; // serial clock down while selected
   assign pin_rst = ~pin_s2_reg[`OSDC_PIN_RST_N];
   assign sel = ~pin_s2_reg[`OSDC_PIN_CE_N];
   assign ce_fall = ce_n_d_reg & ~pin_s2_reg[`OSDC_PIN_CE_N];
   assign ce_rise = ~ce_n_d_reg & pin_s2_reg[`OSDC_PIN_CE_N];
   // edges only count while selected, so a stray clock is ignored
   assign sclk_rise = sel & ~ce_fall & ~sclk_d_reg & pin_s2_reg[`OSDC_PIN_SCLK];
   assign sclk_fall = sel & ~ce_fall & sclk_d_reg & ~pin_s2_reg[`OSDC_PIN_SCLK];

   // ------------------------------------------------------------
   // shift register, latch, timer
   // ------------------------------------------------------------
   // state is split into four groups, each a next-value process and a
   // flop process; the groups share the decoded events and also read shift_reg, tmr_done
   logic [`OSDC_WIDTH-1:0] shift_reg; // one bit per output
   logic [`OSDC_WIDTH-1:0] shift_next; // shift register next value
   logic [`OSDC_WIDTH-1:0] latch_reg; // off bits are one
   logic [`OSDC_WIDTH-1:0] latch_next; // latch next value
   logic [`OSDC_WIDTH-1:0] fault_clr; // channel on while its pin reads high
   logic so_reg; // bit on the serial output
   logic so_next; // serial output bit next value
   logic so_en_reg; // serial output driven
   logic so_en_next; // drive enable next value
   logic [`OSDC_CNT_W-1:0] tmr_reg; // blanking cycles left
   logic [`OSDC_CNT_W-1:0] tmr_next; // timer next value
   logic tmr_done; // blanking over, fault clearing allowed

   // ------------------------------------------------------------
   // shift register group
   // ------------------------------------------------------------
   // jam at selection, then one bit in per falling serial clock;
   // an edge in the selection cycle is masked in the decode above
   always_comb begin
      shift_next = shift_reg;
      if (ce_fall) begin
         // comparator levels: one for a pin that reads high
         shift_next = cmp_s2_reg;
      end else if (sclk_fall) begin
         // shift in at bit 0 so earlier bits march out the top
         shift_next = {shift_reg[`OSDC_MSB-1:0], pin_s2_reg[`OSDC_PIN_SI]};
      end else begin
         // no event: hold, so any bit count passes through
         shift_next = shift_reg;
      end
   end

   // shift register flops; pin reset clears like the system reset
   always_ff @(posedge clk) begin
      if (rst || pin_rst) begin
         shift_reg <= `OSDC_BYTE_ZERO;
      end else if (ce) begin
         shift_reg <= shift_next;
      end
   end

   // ------------------------------------------------------------
   // serial output group
   // ------------------------------------------------------------
   // the bit changes only after a rising serial clock, so the host has
   // a whole high phase to sample it before the next falling edge
   always_comb begin
      so_next = so_reg;
      // driven only while selected, floated otherwise
      so_en_next = sel;
      if (sclk_rise) begin
         // top bit leaves first, so output 07 leads the frame
         so_next = shift_reg[`OSDC_MSB];
      end
   end

   // serial output flops; reset floats the pin whatever the select
   always_ff @(posedge clk) begin
      if (rst || pin_rst) begin
         so_reg <= 1'b0;
         so_en_reg <= 1'b0;
      end else if (ce) begin
         so_reg <= so_next;
         so_en_reg <= so_en_next;
      end
   end

   // ------------------------------------------------------------
   // blanking timer group
   // ------------------------------------------------------------
   // counts system clocks, so the blanking span scales with the clock;
   // a deselect while it runs restarts the full span
   assign tmr_done = (tmr_reg == '0);
   always_comb begin
      tmr_next = tmr_reg;
      if (ce_rise) begin
         // reload at every deselect
         tmr_next = `OSDC_CNT_W'(`OSDC_BLANK_CYCLES);
      end else if (!tmr_done) begin
         // count down and stop at zero
         tmr_next = tmr_reg - `OSDC_CNT_W'(1);
      end
   end

   // timer flops; reset leaves it idle
   always_ff @(posedge clk) begin
      if (rst || pin_rst) begin
         tmr_reg <= '0;
      end else if (ce) begin
         tmr_reg <= tmr_next;
      end
   end

   // ------------------------------------------------------------
   // output latch group
   // ------------------------------------------------------------
   // one fault check per channel: only an on bit (zero) whose pin still
   // reads high after blanking is set to off; off bits never change here
   for (genvar g = 0; g < `OSDC_WIDTH; g++) begin : g_fault
      assign fault_clr[g] = tmr_done & ~latch_reg[g] & cmp_s2_reg[g];
   end

   // a deselect loads the latch and restarts blanking, so it wins over
   // a fault clear falling in the same cycle
   always_comb begin
      latch_next = latch_reg;
      if (ce_rise) begin
         latch_next = shift_reg;
      end else begin
         // clearing keeps running for as long as the fault stands
         latch_next = latch_reg | fault_clr;
      end
   end

   // latch flops; reset turns every output off
   always_ff @(posedge clk) begin
      if (rst || pin_rst) begin
         latch_reg <= `OSDC_BYTE_OFF;
      end else if (ce) begin
         latch_reg <= latch_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // drive is latch bit inverted: zero written means on
   assign drive_on = ~latch_reg;
   assign blanking = ~tmr_done;
   assign link.so_o = so_reg;
   assign link.so_oe_n = ~so_en_reg;
endmodule
`default_nettype wire

// >>> src/osdc_host.sv
// host end: sends one byte per request, returns diagnostic byte
// assumes the resolved serial output wire is asynchronous to clk
`include "osdc_defines.svh"
`default_nettype none
module osdc_host
   import osdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   osdc_link_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [`OSDC_WIDTH-1:0] req_on,
   output logic rsp_valid,
   output logic [`OSDC_WIDTH-1:0] rsp_diag,
   input wire logic dev_reset_n_in
);
   // ------------------------------------------------------------
   // serial input synchroniser
   // ------------------------------------------------------------
   logic so_s1_reg; // first stage only
   logic so_s2_reg; // usable sample
   always_ff @(posedge clk) begin
      if (rst) begin
         so_s1_reg <= 1'b0;
         so_s2_reg <= 1'b0;
      end else if (ce) begin
         so_s1_reg <= link.so;
         so_s2_reg <= so_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // transfer sequencer
   // ------------------------------------------------------------
   osdc_host_state_t st_reg, st_next;
   logic [`OSDC_CNT_W-1:0] cnt_reg, cnt_next; // phase timer
   logic [2:0] bit_reg, bit_next; // bits left minus one
   logic [`OSDC_WIDTH-1:0] tx_reg, tx_next; // outgoing, off as one
   logic [`OSDC_WIDTH-1:0] rx_reg, rx_next; // diagnostic collected
   logic rsp_reg, rsp_next; // response pulse
   logic sclk_reg, sclk_next;
   logic ce_n_reg, ce_n_next;

   // long half periods keep every edge clear of the device sync delay
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      tx_next = tx_reg;
      rx_next = rx_reg;
      rsp_next = 1'b0;
      sclk_next = sclk_reg;
      ce_n_next = ce_n_reg;
      if (cnt_reg != '0) begin
         cnt_next = cnt_reg - `OSDC_CNT_W'(1);
      end else begin
         case (st_reg)
            OSDC_H_IDLE: begin
               if (req_valid) begin
                  tx_next = ~req_on;
                  ce_n_next = 1'b0; // clock low at selection
                  bit_next = 3'(`OSDC_MSB);
                  cnt_next = `OSDC_CNT_W'(`OSDC_HALF_CYCLES);
                  st_next = OSDC_H_LEAD;
               end
            end
            OSDC_H_LEAD, OSDC_H_LOW: begin
               // next data bit moves with the rise, half a period clear of
               // the falling edge at which the device samples it
               if (st_reg == OSDC_H_LOW) begin
                  tx_next = {tx_reg[`OSDC_MSB-1:0], 1'b1};
               end
               sclk_next = 1'b1;
               cnt_next = `OSDC_CNT_W'(`OSDC_HALF_CYCLES);
               st_next = OSDC_H_HIGH;
            end
            OSDC_H_HIGH: begin
               // sample device bit before falling edge, top first
               rx_next = {rx_reg[`OSDC_MSB-1:0], so_s2_reg};
               sclk_next = 1'b0;
               cnt_next = `OSDC_CNT_W'(`OSDC_HALF_CYCLES);
               if (bit_reg == '0) begin
                  st_next = OSDC_H_LAG;
               end else begin
                  bit_next = bit_reg - 3'(1);
                  st_next = OSDC_H_LOW;
               end
            end
            OSDC_H_LAG: begin
               ce_n_next = 1'b1; // clock is low here
               rsp_next = 1'b1;
               cnt_next = `OSDC_CNT_W'(`OSDC_HALF_CYCLES);
               st_next = OSDC_H_IDLE;
            end
            default: st_next = OSDC_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= OSDC_H_IDLE;
         cnt_reg <= '0;
         bit_reg <= '0;
         tx_reg <= `OSDC_BYTE_OFF;
         rx_reg <= `OSDC_BYTE_ZERO;
         rsp_reg <= 1'b0;
         sclk_reg <= 1'b0;
         ce_n_reg <= 1'b1;
      end else if (ce) begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         tx_reg <= tx_next;
         rx_reg <= rx_next;
         rsp_reg <= rsp_next;
         sclk_reg <= sclk_next;
         ce_n_reg <= ce_n_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign req_ready = (st_reg == OSDC_H_IDLE) && (cnt_reg == '0);
   assign rsp_valid = rsp_reg;
   assign rsp_diag = rx_reg; // decoding left to the user
   assign link.sclk = sclk_reg;
   assign link.ce_n = ce_n_reg;
   assign link.si = tx_reg[`OSDC_MSB];
   assign link.reset_n = dev_reset_n_in; // never left floating
endmodule
`default_nettype wire

// >>> src/osdc_link_if.sv
// the four-wire serial link plus asynchronous reset line
// assumes the bench resolves the serial output wire from its enable
`include "osdc_defines.svh"
`default_nettype none
interface osdc_link_if;
   logic sclk;      // serial clock, host driven
   logic ce_n;      // chip enable, active low
   logic si;        // host to device data
   logic so_o;      // device data out value
   logic so_oe_n;   // device drive enable, low while driving
   logic so;        // resolved wire, settled by the bench
   logic reset_n;   // device reset, active low
   modport device (input sclk, ce_n, si, reset_n, output so_o, so_oe_n);
   modport host (output sclk, ce_n, si, reset_n, input so);
endinterface
`default_nettype wire

// >>> src/osdc_pkg.sv
// types shared by both ends of the octal serial driver link
// assumes osdc_defines.svh is on the include path
`include "osdc_defines.svh"
`default_nettype none
package osdc_pkg;
   // host transfer sequencer states
   typedef enum logic [2:0] {
      OSDC_H_IDLE,
      OSDC_H_LEAD,
      OSDC_H_HIGH,
      OSDC_H_LOW,
      OSDC_H_LAG
   } osdc_host_state_t;
   typedef logic [`OSDC_WIDTH-1:0] osdc_byte_t;
endpackage
`default_nettype wire

// >>> tb/osdc_link_assertions.sv
// link checker: timing relations on the serial wires
// assumes the bench instantiates it beside the link interface
`default_nettype none
module osdc_link_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic ce_n,
   input wire logic so_o,
   input wire logic so_oe_n,
   input wire logic reset_n
);
   // ------------------------------
   // helper ages
   // ------------------------------
   logic sclk_d_reg, sclk_d_next; // sclk one cycle back
   logic [7:0] move_reg, move_next; // cycles since sclk moved
   logic [7:0] rise_reg, rise_next; // cycles since sclk rose
   // ages saturate so a long idle never wraps to a small value
   always_comb begin
      sclk_d_next = sclk;
      move_next = (move_reg == 8'hFF) ? 8'hFF : move_reg + 8'h01;
      rise_next = (rise_reg == 8'hFF) ? 8'hFF : rise_reg + 8'h01;
      // any edge restarts the move age
      if (sclk != sclk_d_reg) begin
         move_next = 8'h00;
      end
      // rising edge restarts the rise age
      if (sclk && !sclk_d_reg) begin
         rise_next = 8'h00;
      end
   end
   // registers only
   always_ff @(posedge clk) begin
      if (rst) begin
         {sclk_d_reg, move_reg, rise_reg} <= {1'b0, 8'hFF, 8'hFF};
      end else begin
         {sclk_d_reg, move_reg, rise_reg} <= {sclk_d_next, move_next, rise_next};
      end
   end
   // ------------------------------
   // properties
   // ------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_desel;
      ce_n [*8];
   endsequence
   sequence s_sel;
      (!ce_n && reset_n) [*8];
   endsequence
   chk_float_idle: assert property (s_desel |-> so_oe_n)
      else $error("serial out driven while deselected");
   chk_drive_sel: assert property (s_sel |-> !so_oe_n)
      else $error("serial out not driven while selected");
   chk_reset_float: assert property ((!reset_n) [*8] |-> so_oe_n)
      else $error("serial out driven during reset");
   chk_sclk_low_fall: assert property ($fell(ce_n) |-> !sclk)
      else $error("serial clock high at select");
   chk_sclk_low_rise: assert property ($rose(ce_n) |-> !sclk)
      else $error("serial clock high at deselect");
   chk_ce_lag: assert property ($rose(ce_n) |-> move_reg >= 8'h04)
      else $error("deselect too close to last clock edge");
   chk_so_after_rise: assert property (!so_oe_n && $changed(so_o) |-> rise_reg <= 8'h08)
      else $error("serial out moved without a clock rise");
   chk_sclk_in_frame: assert property (sclk |-> !ce_n)
      else $error("serial clock active while deselected");
endmodule
`default_nettype wire

// >>> tb/osdc_tb.sv
// bench: host end drives device end over the link
// assumes design sources and the link checker compile first
`include "osdc_defines.svh"
`default_nettype none
module osdc_tb
   import osdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // signals
   // ------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1; // clock enable, dropped once for the frozen check
   logic req_valid = 1'b0;
   logic dev_reset_n = 1'b1; // device reset pin
   logic so_last = 1'b0; // last driven serial out
   logic req_ready, rsp_valid, blanking;
   osdc_byte_t req_on = 8'h00;
   osdc_byte_t fault = 8'h00; // pins held high by overload
   osdc_byte_t rsp_diag, drive_on, out_high, si_seen, so_seen;
   int num_errors = 0;
   int n_tests = 0;
   osdc_link_if link ();
   always #2.5 clk = ~clk;
   // low-side pins read high when off, or on but overloaded
   assign out_high = ~drive_on | fault;
   // a released wire shows the inverse of its last value, not a stale copy
   always @(posedge clk) if (!link.so_oe_n) so_last <= link.so_o;
   assign link.so = link.so_oe_n ? ~so_last : link.so_o;
   // wire monitor: both data wires are steady at the falling serial clock
   always @(negedge link.sclk) if (!link.ce_n) si_seen <= {si_seen[6:0], link.si};
   always @(negedge link.sclk) if (!link.ce_n) so_seen <= {so_seen[6:0], link.so};
   // ------------------------------
   // instances
   // ------------------------------
   osdc_device osdc_device_i (.clk(clk), .rst(rst), .ce(ce), .link(link.device),
      .out_high(out_high), .drive_on(drive_on), .blanking(blanking));
   osdc_host osdc_host_i (.clk(clk), .rst(rst), .ce(ce), .link(link.host),
      .req_valid(req_valid), .req_ready(req_ready), .req_on(req_on), .rsp_valid(rsp_valid),
      .rsp_diag(rsp_diag), .dev_reset_n_in(dev_reset_n));
   osdc_link_assertions osdc_link_assertions_i (.clk(clk), .rst(rst), .sclk(link.sclk),
      .ce_n(link.ce_n), .so_o(link.so_o), .so_oe_n(link.so_oe_n), .reset_n(link.reset_n));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic check(input string what, input osdc_byte_t seen, input osdc_byte_t exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one byte each way; checks wire, answer and latch
   task automatic xfer(input osdc_byte_t on, input osdc_byte_t diag);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 1000) begin
         @(negedge clk);
         k++;
      end
      check("ready_wait", {7'h00, req_ready}, 8'h01);
      @(posedge clk);
      req_valid <= 1'b1;
      req_on <= on;
      @(posedge clk);
      req_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (rsp_valid !== 1'b1 && k < 5000);
      check("rsp_wait", {7'h00, rsp_valid}, 8'h01);
      check("rsp_diag", rsp_diag, diag);
      check("so_wire", so_seen, diag);
      check("si_wire", si_seen, ~on);
      repeat (10) @(negedge clk);
      check("drive_on", drive_on, on);
      check("blanking", {7'h00, blanking}, 8'h01);
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      int k;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("drive_on", drive_on, 8'h00);
      check("so_oe_n", {7'h00, link.so_oe_n}, 8'h01);
      xfer(8'hA5, 8'hFF);
      // rewrite the same byte once the outputs have settled past blanking
      repeat (`OSDC_BLANK_CYCLES) @(negedge clk);
      // frozen clock enable: a fault on on-outputs must not clear the latch
      @(posedge clk);
      ce <= 1'b0;
      fault <= 8'hFF;
      repeat (20) @(negedge clk);
      check("drive_frozen", drive_on, 8'hA5);
      @(posedge clk);
      ce <= 1'b1;
      fault <= 8'h00;
      xfer(8'hA5, 8'h5A);
      @(posedge clk);
      fault <= 8'h81;
      // faults on outputs 07 and 00 stay latched while blanking runs
      xfer(8'hC3, 8'hDB);
      k = 0;
      while (blanking === 1'b1 && k < 30000) begin
         @(negedge clk);
         k++;
      end
      check("blank_len", {7'h00, k > 26950 && k < 27010}, 8'h01);
      repeat (10) @(negedge clk);
      check("drive_on", drive_on, 8'h42);
      @(posedge clk);
      dev_reset_n <= 1'b0;
      fault <= 8'h00;
      repeat (12) @(negedge clk);
      check("drive_on", drive_on, 8'h00);
      check("so_oe_n", {7'h00, link.so_oe_n}, 8'h01);
      check("blanking", {7'h00, blanking}, 8'h00);
      @(posedge clk);
      dev_reset_n <= 1'b1;
      repeat (12) @(negedge clk);
      xfer(8'h00, 8'hFF);
      conclude();
   end
   // watchdog: well past the expected run of about 345 us
   initial begin
      #480000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
